// File: design/ccpt_pkg.sv
package ccpt_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_COUNTER_STATUS_CONTROL = 6'h20;
    localparam logic [5:0] IDX_COUNT_VALUE_HIGH = 6'h21;
    localparam logic [5:0] IDX_COUNT_VALUE_LOW = 6'h22;
    localparam logic [5:0] IDX_WRAP_VALUE_HIGH = 6'h23;
    localparam logic [5:0] IDX_WRAP_VALUE_LOW = 6'h24;
    localparam logic [5:0] IDX_CHAN0_STATUS_CONTROL = 6'h25;
    localparam logic [5:0] IDX_CHAN0_VALUE_HIGH = 6'h26;
    localparam logic [5:0] IDX_CHAN0_VALUE_LOW = 6'h27;
    localparam logic [5:0] IDX_CHAN1_STATUS_CONTROL = 6'h28;
    localparam logic [5:0] IDX_CHAN1_VALUE_HIGH = 6'h29;
    localparam logic [5:0] IDX_CHAN1_VALUE_LOW = 6'h2A;

    // counter_status_control field positions
    localparam int BIT_WRAP_FLAG = 7;
    localparam int BIT_WRAP_IRQ_ENABLE = 6;
    localparam int BIT_COUNTER_HALT = 5;
    localparam int BIT_COUNTER_CLEAR = 4;
    localparam int BIT_PRESCALE_LSB = 0;

    // channel status_control field position of the event flag
    localparam int BIT_CHANNEL_EVENT_FLAG = 7;

    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [2:0] PRESCALE_NONE = 3'h7;
    localparam logic [15:0] WRAP_RESET = 16'hFFFF;
    localparam logic COUNTER_HALT_RESET = 1'b1;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_OFF = 2'h0;

    // bit order matches the register byte, flag in bit 7
    typedef struct packed {
        logic channel_event_flag;
        logic channel_irq_enable;
        logic buffered_mode_select;
        logic unbuffered_mode_select;
        logic [1:0] edge_level_select;
        logic toggle_on_wrap;
        logic full_duty_force;
    } ccpt_ctl_t;

    typedef struct packed {
        ccpt_ctl_t ctl;
        logic [15:0] value;
        logic clr_armed;
        logic cap_block;
        logic cmp_block;
        logic max_eff;
        logic pin_lvl;
        logic pin_oe;
    } ccpt_chan_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ccpt_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ccpt_apb_rsp_t;

endpackage : ccpt_pkg

// File: design/ccpt_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ccpt_timer
    import ccpt_pkg::*;
#(
    parameter int NUM_CHAN = 2
) (
    input wire logic clk,                        // bus clock, 40 MHz
    input wire logic srst,                       // synchronous reset, active high
    input wire ccpt_pkg::ccpt_apb_req_t apb_req, // apb request from master
    output var ccpt_pkg::ccpt_apb_rsp_t apb_rsp, // apb answer
    input wire logic dbg_break,                  // debug break state, same clock
    input wire logic [NUM_CHAN-1:0] chan_pin_in, // channel pin levels, async
    output logic [NUM_CHAN-1:0] chan_pin_out,    // channel pin drive level
    output logic [NUM_CHAN-1:0] chan_pin_oe,     // high while timer drives pin
    output logic wrap_irq,                       // wrap interrupt request
    output logic [NUM_CHAN-1:0] chan_irq         // channel interrupt requests
);
    import ccpt_pkg::*;

    typedef struct packed {
        logic wrap_flag;
        logic wrap_irq_enable;
        logic counter_halt;
        logic [2:0] prescale_select;
        logic [5:0] pre;
        logic [15:0] cnt;
        logic [15:0] wrap;
        logic wrap_armed;
        logic wrap_block;
        logic lo_latched;
        logic [7:0] lo_buf;
        logic [7:0] snap_lo;
        ccpt_chan_t [NUM_CHAN-1:0] ch;
        logic buf_active;
        logic buf_pending;
        logic [NUM_CHAN-1:0] sync1;
        logic [NUM_CHAN-1:0] sync2;
        logic [NUM_CHAN-1:0] prev;
        ccpt_apb_rsp_t rsp;
        logic wrap_irq;
        logic [NUM_CHAN-1:0] chan_irq;
    } ccpt_state_t;

    ccpt_state_t s_q;
    ccpt_state_t s_d;

    function automatic logic [5:0] prescale_mask(input logic [2:0] sel);
        logic [5:0] m;
        m = 6'h00;
        for (int b = 0; b < 6; b++) begin
            if (b < int'(sel)) begin
                m[b] = 1'b1;
            end
        end
        return m;
    endfunction : prescale_mask

    function automatic logic is_capture(input ccpt_ctl_t c);
        return !c.buffered_mode_select && !c.unbuffered_mode_select
            && (c.edge_level_select != ELS_OFF);
    endfunction : is_capture

    function automatic logic is_compare(input ccpt_ctl_t c);
        return (c.buffered_mode_select || c.unbuffered_mode_select)
            && (c.edge_level_select != ELS_OFF);
    endfunction : is_compare

    always_comb begin
        logic [5:0] idx;
        logic setup;
        logic access;
        logic wr;
        logic rd;
        logic halted;
        logic tick;
        logic ovf;
        logic buffered;
        logic ch_en;
        logic rise;
        logic fall;
        logic cap_ev;
        logic cmp_ev;
        logic ov_act;
        logic pulse;
        logic [15:0] cmp_val;
        logic cmp_blk;
        logic [7:0] wb;
        logic [NUM_CHAN-1:0] ch_ev;
        ccpt_ctl_t c;
        ccpt_ctl_t wc;

        s_d = s_q;
        idx = apb_req.paddr[7:2];
        wb = apb_req.pwdata[7:0];
        wc = ccpt_ctl_t'(wb);
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && s_q.rsp.pready;
        wr = access && apb_req.pwrite && !s_q.rsp.pslverr;
        rd = access && !apb_req.pwrite && !s_q.rsp.pslverr;
        buffered = s_q.ch[0].ctl.buffered_mode_select;
        ch_ev = '0;

        // only sync2 reads sync1; two flops settle the async pins, prev keeps the last level for edges
        s_d.sync1 = chan_pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;

        // prescaler and counter
        halted = s_q.counter_halt || dbg_break;
        tick = 1'b0;
        if (!halted) begin
            s_d.pre = s_q.pre + 6'h01;
            tick = (s_q.prescale_select != PRESCALE_NONE)
                && ((s_q.pre & prescale_mask(s_q.prescale_select))
                    == prescale_mask(s_q.prescale_select));
        end
        ovf = tick && (s_q.cnt == s_q.wrap);
        if (tick) begin
            s_d.cnt = ovf ? 16'h0000 : s_q.cnt + 16'h0001;
        end
        if (ovf) begin
            s_d.buf_active = s_q.buf_pending;
        end

        // channel events, computed from the registered state
        for (int i = 0; i < NUM_CHAN; i++) begin
            c = s_q.ch[i].ctl;
            ch_en = !(i == 1 && buffered);
            if (i != 0) begin
                c.buffered_mode_select = 1'b0;
            end
            rise = s_q.sync2[i] && !s_q.prev[i];
            fall = !s_q.sync2[i] && s_q.prev[i];
            cap_ev = ch_en && is_capture(c) && !s_q.ch[i].cap_block
                && ((c.edge_level_select[0] && rise)
                    || (c.edge_level_select[1] && fall));
            if (i == 0 && buffered) begin
                cmp_val = s_q.ch[s_q.buf_active].value;
                cmp_blk = s_q.ch[s_q.buf_active].cmp_block;
            end else begin
                cmp_val = s_q.ch[i].value;
                cmp_blk = s_q.ch[i].cmp_block;
            end
            cmp_ev = ch_en && is_compare(c) && tick
                && (s_q.cnt == cmp_val) && !cmp_blk;
            ov_act = ch_en && is_compare(c) && c.toggle_on_wrap && ovf;
            pulse = !c.edge_level_select[0];
            if (cap_ev) begin
                s_d.ch[i].value = s_q.cnt;
            end
            if (!ch_en || c.edge_level_select == ELS_OFF) begin
                s_d.ch[i].pin_oe = 1'b0;
                s_d.ch[i].pin_lvl = !c.unbuffered_mode_select;
            end else if (is_compare(c)) begin
                s_d.ch[i].pin_oe = 1'b1;
                if (ov_act) begin
                    // wrap wins over a same-cycle match
                    if (s_q.ch[i].max_eff && c.edge_level_select != ELS_TOGGLE) begin
                        s_d.ch[i].pin_lvl = pulse;
                    end else begin
                        s_d.ch[i].pin_lvl = !s_q.ch[i].pin_lvl;
                    end
                end else if (cmp_ev && !(s_q.ch[i].max_eff && c.toggle_on_wrap)) begin
                    // without wrap toggles a clear or set match keeps forcing one fixed level; a toggle match still toggles
                    unique case (c.edge_level_select)
                        ELS_TOGGLE: s_d.ch[i].pin_lvl = !s_q.ch[i].pin_lvl;
                        ELS_CLEAR: s_d.ch[i].pin_lvl = 1'b0;
                        default: s_d.ch[i].pin_lvl = 1'b1;
                    endcase
                end
                if (ovf) begin
                    s_d.ch[i].max_eff = c.full_duty_force;
                end
            end else begin
                s_d.ch[i].pin_oe = 1'b0;
            end
            ch_ev[i] = cap_ev || cmp_ev;
        end

        // apb setup: snapshot read data, answer in the access cycle
        s_d.rsp.pready = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        if (setup && !s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.pslverr = (apb_req.paddr[1:0] != 2'b00)
                || (idx < IDX_COUNTER_STATUS_CONTROL)
                || (idx > IDX_CHAN1_VALUE_LOW);
            s_d.rsp.prdata = 32'h0000_0000;
            s_d.snap_lo = s_q.cnt[7:0];
            unique case (idx)
                IDX_COUNTER_STATUS_CONTROL: begin
                    s_d.rsp.prdata[BIT_WRAP_FLAG] = s_q.wrap_flag;
                    s_d.rsp.prdata[BIT_WRAP_IRQ_ENABLE] = s_q.wrap_irq_enable;
                    s_d.rsp.prdata[BIT_COUNTER_HALT] = s_q.counter_halt;
                    s_d.rsp.prdata[BIT_PRESCALE_LSB +: 3] = s_q.prescale_select;
                end
                IDX_COUNT_VALUE_HIGH: s_d.rsp.prdata[7:0] = s_q.cnt[15:8];
                IDX_COUNT_VALUE_LOW: begin
                    s_d.rsp.prdata[7:0] = s_q.lo_latched ? s_q.lo_buf : s_q.cnt[7:0];
                end
                IDX_WRAP_VALUE_HIGH: s_d.rsp.prdata[7:0] = s_q.wrap[15:8];
                IDX_WRAP_VALUE_LOW: s_d.rsp.prdata[7:0] = s_q.wrap[7:0];
                IDX_CHAN0_STATUS_CONTROL: s_d.rsp.prdata[7:0] = 8'(s_q.ch[0].ctl);
                IDX_CHAN0_VALUE_HIGH: s_d.rsp.prdata[7:0] = s_q.ch[0].value[15:8];
                IDX_CHAN0_VALUE_LOW: s_d.rsp.prdata[7:0] = s_q.ch[0].value[7:0];
                IDX_CHAN1_STATUS_CONTROL: s_d.rsp.prdata[7:0] = 8'(s_q.ch[1].ctl);
                IDX_CHAN1_VALUE_HIGH: s_d.rsp.prdata[7:0] = s_q.ch[1].value[15:8];
                IDX_CHAN1_VALUE_LOW: s_d.rsp.prdata[7:0] = s_q.ch[1].value[7:0];
                default: s_d.rsp.prdata = 32'h0000_0000;
            endcase
        end

        // read side effects take place at the completing edge
        if (rd) begin
            unique case (idx)
                IDX_COUNTER_STATUS_CONTROL: begin
                    if (s_q.wrap_flag) begin
                        s_d.wrap_armed = 1'b1;
                    end
                end
                IDX_COUNT_VALUE_HIGH: begin
                    if (!s_q.lo_latched) begin
                        s_d.lo_latched = 1'b1;
                        s_d.lo_buf = s_q.snap_lo;
                    end
                end
                IDX_COUNT_VALUE_LOW: s_d.lo_latched = 1'b0;
                IDX_CHAN0_STATUS_CONTROL: begin
                    if (s_q.ch[0].ctl.channel_event_flag) begin
                        s_d.ch[0].clr_armed = 1'b1;
                    end
                end
                IDX_CHAN1_STATUS_CONTROL: begin
                    if (s_q.ch[1].ctl.channel_event_flag) begin
                        s_d.ch[1].clr_armed = 1'b1;
                    end
                end
                IDX_CHAN0_VALUE_HIGH: begin
                    if (is_capture(s_q.ch[0].ctl)) begin
                        s_d.ch[0].cap_block = 1'b1;
                    end
                end
                IDX_CHAN1_VALUE_HIGH: begin
                    if (is_capture(s_q.ch[1].ctl)) begin
                        s_d.ch[1].cap_block = 1'b1;
                    end
                end
                IDX_CHAN0_VALUE_LOW: s_d.ch[0].cap_block = 1'b0;
                IDX_CHAN1_VALUE_LOW: s_d.ch[1].cap_block = 1'b0;
                default: s_d.lo_latched = s_q.lo_latched;
            endcase
        end

        if (wr) begin
            unique case (idx)
                IDX_COUNTER_STATUS_CONTROL: begin
                    if (!wb[BIT_WRAP_FLAG] && s_q.wrap_armed) begin
                        s_d.wrap_flag = 1'b0;
                    end
                    s_d.wrap_armed = 1'b0;
                    s_d.wrap_irq_enable = wb[BIT_WRAP_IRQ_ENABLE];
                    s_d.counter_halt = wb[BIT_COUNTER_HALT];
                    s_d.prescale_select = wb[BIT_PRESCALE_LSB +: 3];
                    if (wb[BIT_COUNTER_CLEAR]) begin
                        // clear is never stored, so it reads back as zero
                        s_d.cnt = 16'h0000;
                        s_d.pre = 6'h00;
                    end
                end
                IDX_WRAP_VALUE_HIGH: begin
                    s_d.wrap[15:8] = wb;
                    s_d.wrap_block = 1'b1;
                end
                IDX_WRAP_VALUE_LOW: begin
                    s_d.wrap[7:0] = wb;
                    s_d.wrap_block = 1'b0;
                end
                IDX_CHAN0_STATUS_CONTROL, IDX_CHAN1_STATUS_CONTROL: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                        if ((idx == IDX_CHAN0_STATUS_CONTROL && i == 0)
                            || (idx == IDX_CHAN1_STATUS_CONTROL && i == 1 && !buffered)) begin
                            if (!wc.channel_event_flag && s_q.ch[i].clr_armed) begin
                                s_d.ch[i].ctl.channel_event_flag = 1'b0;
                            end
                            s_d.ch[i].clr_armed = 1'b0;
                            s_d.ch[i].ctl.channel_irq_enable = wc.channel_irq_enable;
                            s_d.ch[i].ctl.buffered_mode_select =
                                (i == 0) ? wc.buffered_mode_select : 1'b0;
                            s_d.ch[i].ctl.unbuffered_mode_select = wc.unbuffered_mode_select;
                            s_d.ch[i].ctl.edge_level_select = wc.edge_level_select;
                            s_d.ch[i].ctl.toggle_on_wrap = wc.toggle_on_wrap;
                            s_d.ch[i].ctl.full_duty_force = wc.full_duty_force;
                        end
                    end
                end
                IDX_CHAN0_VALUE_HIGH, IDX_CHAN1_VALUE_HIGH: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                        if ((idx == IDX_CHAN0_VALUE_HIGH) == (i == 0)) begin
                            s_d.ch[i].value[15:8] = wb;
                            if (!is_capture(s_q.ch[i].ctl)) begin
                                s_d.ch[i].cmp_block = 1'b1;
                            end
                        end
                    end
                end
                IDX_CHAN0_VALUE_LOW, IDX_CHAN1_VALUE_LOW: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                        if ((idx == IDX_CHAN0_VALUE_LOW) == (i == 0)) begin
                            s_d.ch[i].value[7:0] = wb;
                            s_d.ch[i].cmp_block = 1'b0;
                            s_d.buf_pending = (i != 0);
                        end
                    end
                end
                default: s_d.wrap_block = s_q.wrap_block;
            endcase
        end

        // leaving buffered mode restarts the pair from channel 0
        if (!s_d.ch[0].ctl.buffered_mode_select) begin
            s_d.buf_active = 1'b0;
            s_d.buf_pending = 1'b0;
        end

        // events last: a set in the clearing cycle wins and voids the clear
        if (ovf && !s_q.wrap_block) begin
            s_d.wrap_flag = 1'b1;
            s_d.wrap_armed = 1'b0;
        end
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (ch_ev[i]) begin
                s_d.ch[i].ctl.channel_event_flag = 1'b1;
                s_d.ch[i].clr_armed = 1'b0;
            end
        end

        if (srst) begin
            s_d = '0;
            s_d.counter_halt = COUNTER_HALT_RESET;
            s_d.wrap = WRAP_RESET;
            s_d.prescale_select = PRESCALE_RESET;
            for (int i = 0; i < NUM_CHAN; i++) begin
                s_d.ch[i].pin_lvl = 1'b1;
            end
        end

        s_d.wrap_irq = s_d.wrap_flag && s_d.wrap_irq_enable;
        for (int i = 0; i < NUM_CHAN; i++) begin
            s_d.chan_irq[i] = s_d.ch[i].ctl.channel_event_flag
                && s_d.ch[i].ctl.channel_irq_enable;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    always_comb begin
        apb_rsp = s_q.rsp;
        wrap_irq = s_q.wrap_irq;
        chan_irq = s_q.chan_irq;
        for (int i = 0; i < NUM_CHAN; i++) begin
            chan_pin_out[i] = s_q.ch[i].pin_lvl;
            chan_pin_oe[i] = s_q.ch[i].pin_oe;
        end
    end

endmodule : ccpt_timer

`default_nettype wire

// File: tb/ccpt_timer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ccpt_timer_asserts
    import ccpt_pkg::*;
#(
    parameter int NUM_CHAN = 2
) (
    input wire logic clk, // bus clock
    input wire logic srst, // sync reset
    input wire ccpt_pkg::ccpt_apb_req_t apb_req, // apb request
    input wire ccpt_pkg::ccpt_apb_rsp_t apb_rsp, // apb answer
    input wire logic dbg_break, // debug break
    input wire logic [NUM_CHAN-1:0] chan_pin_in, // pin levels
    input wire logic [NUM_CHAN-1:0] chan_pin_out, // pin drive level
    input wire logic [NUM_CHAN-1:0] chan_pin_oe, // pin drive enable
    input wire logic wrap_irq, // wrap request
    input wire logic [NUM_CHAN-1:0] chan_irq // channel requests
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    property p_ready_next;
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
    property p_ready_pulse;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_ready;
        apb_rsp.pslverr |-> apb_rsp.pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rd_upper;
        apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_clr_reads0;
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 8'h80 |-> !apb_rsp.prdata[4];
    endproperty
    a_clr_reads0: assert property (p_clr_reads0) else $error("clear bit read as one");
    property p_reset_out;
        $fell(srst) |-> !wrap_irq && chan_irq == '0 && chan_pin_oe == '0;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
    property p_wrap_fall;
        $fell(wrap_irq) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_wrap_fall: assert property (p_wrap_fall) else $error("wrap request dropped alone");
    property p_chan_fall;
        |($past(chan_irq) & ~chan_irq) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_chan_fall: assert property (p_chan_fall) else $error("channel request dropped alone");
    property p_oe_change;
        chan_pin_oe != $past(chan_pin_oe) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_oe_change: assert property (p_oe_change) else $error("pin enable moved alone");
    c_write: cover property (wr && apb_rsp.pready);
    c_wrap: cover property ($rose(wrap_irq));
    c_chan: cover property ($rose(chan_irq[0]));
    c_oe: cover property ($rose(chan_pin_oe[1]));
endmodule : ccpt_timer_asserts
bind ccpt_timer ccpt_timer_asserts #(.NUM_CHAN(NUM_CHAN)) u_chk (.clk(clk), .srst(srst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .dbg_break(dbg_break), .chan_pin_in(chan_pin_in),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .wrap_irq(wrap_irq),
    .chan_irq(chan_irq));
`default_nettype wire

// File: tb/ccpt_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module ccpt_pin_model #(
    parameter int NUM_CHAN = 2
) (
    input wire logic clk, // bus clock
    input wire logic [NUM_CHAN-1:0] ext_lvl, // port level asked for
    input wire logic [NUM_CHAN-1:0] pin_out, // timer drive level
    input wire logic [NUM_CHAN-1:0] pin_oe, // timer drive enable
    output logic [NUM_CHAN-1:0] pin_in // resolved pin level
);
    logic [NUM_CHAN-1:0] port_q = '0;
    // port moves only on an edge, so it is stable well over two clocks
    always @(posedge clk) port_q <= ext_lvl;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & port_q);
endmodule : ccpt_pin_model
`default_nettype wire

// File: tb/ccpt_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ccpt_timer_bench;
    import ccpt_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic dbg_break = 1'b0;
    logic [1:0] ext_lvl = 2'h0;
    ccpt_apb_req_t apb_req = '0;
    ccpt_apb_rsp_t apb_rsp;
    logic [1:0] pin_in, pin_out, pin_oe, chan_irq;
    logic wrap_irq, err;
    logic [31:0] rd;
    logic [7:0] v0;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    ccpt_timer u_dut (.clk(clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .dbg_break(dbg_break), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe(pin_oe), .wrap_irq(wrap_irq), .chan_irq(chan_irq));
    ccpt_pin_model u_pins (.clk(clk), .ext_lvl(ext_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {24'h0, wd}};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        // this wait ends once pready is seen high, else at the bench timeout
        do begin
            @(posedge clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : xfer
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        xfer(1'b0, 8'h80, 8'h00); check("status", rd, 32'h20);
        xfer(1'b0, 8'h8C, 8'h00); check("wrap_high", rd, 32'hFF);
        xfer(1'b0, 8'h90, 8'h00); check("wrap_low", rd, 32'hFF);
        xfer(1'b0, 8'h88, 8'h00); check("halted_count", rd, 32'h0);
        xfer(1'b1, 8'h80, 8'h01);
        repeat (40) @(posedge clk);
        xfer(1'b1, 8'h80, 8'h31);
        xfer(1'b0, 8'h88, 8'h00); check("cleared_count", rd, 32'h0);
        xfer(1'b0, 8'h80, 8'h00); check("status_kept", rd, 32'h21);
        // freeze by break, latch low byte, then let exactly ten ticks pass
        xfer(1'b1, 8'h80, 8'h00);
        dbg_break <= 1'b1;
        xfer(1'b0, 8'h88, 8'h00);
        v0 = rd[7:0];
        xfer(1'b0, 8'h88, 8'h00); check("break_count", rd, {24'h0, v0});
        xfer(1'b0, 8'h84, 8'h00);
        dbg_break <= 1'b0;
        repeat (10) @(posedge clk);
        dbg_break <= 1'b1;
        xfer(1'b0, 8'h88, 8'h00); check("latched_low", rd, {24'h0, v0});
        xfer(1'b0, 8'h88, 8'h00); check("live_low", rd, {24'h0, v0 + 8'h0A});
        dbg_break <= 1'b0;
        xfer(1'b1, 8'h80, 8'h30);
        xfer(1'b1, 8'h8C, 8'h00);
        xfer(1'b1, 8'h90, 8'h09);
        xfer(1'b1, 8'h80, 8'h40);
        for (int i = 0; i < 60 && wrap_irq !== 1'b1; i++) @(posedge clk);
        check("wrap_irq", 32'(wrap_irq), 32'h1);
        xfer(1'b1, 8'h80, 8'h60);
        xfer(1'b0, 8'h80, 8'h00); check("flag_kept", rd, 32'hE0);
        xfer(1'b1, 8'h80, 8'h60);
        xfer(1'b0, 8'h80, 8'h00); check("flag_cleared", rd, 32'h60);
        check("wrap_irq_low", 32'(wrap_irq), 32'h0);
        xfer(1'b0, 8'h88, 8'h00); check("count_in_range", 32'(rd <= 32'h9), 32'h1);
        v0 = rd[7:0];
        xfer(1'b1, 8'h94, 8'h44);
        ext_lvl <= 2'h1;
        for (int i = 0; i < 20 && chan_irq[0] !== 1'b1; i++) @(posedge clk);
        check("capture_irq", 32'(chan_irq[0]), 32'h1);
        xfer(1'b0, 8'h98, 8'h00); check("capture_high", rd, 32'h0);
        xfer(1'b0, 8'h9C, 8'h00); check("capture_low", rd, {24'h0, v0});
        xfer(1'b0, 8'h94, 8'h00); check("chan0_status", rd, 32'hC4);
        xfer(1'b1, 8'h94, 8'h44);
        ext_lvl <= 2'h0;
        repeat (10) @(posedge clk);
        check("falling_ignored", 32'(chan_irq[0]), 32'h0);
        xfer(1'b1, 8'hA4, 8'h00);
        xfer(1'b1, 8'hA8, 8'h05);
        xfer(1'b1, 8'hA0, 8'h18);
        // enable is registered one edge after the control byte lands
        repeat (2) @(posedge clk);
        check("compare_oe", 32'(pin_oe), 32'h2);
        xfer(1'b1, 8'h80, 8'h00);
        for (int i = 0; i < 40 && pin_out[1] !== 1'b0; i++) @(posedge clk);
        check("compare_clear", 32'(pin_out[1]), 32'h0);
        xfer(1'b0, 8'hA0, 8'h00); check("chan1_status", rd, 32'h98);
        xfer(1'b1, 8'h94, 8'h38);
        repeat (2) @(posedge clk);
        check("buffered_oe", 32'(pin_oe), 32'h1);
        for (int i = 0; i < 40 && pin_out[0] !== 1'b0; i++) @(posedge clk);
        check("buffered_clear", 32'(pin_out[0]), 32'h0);
        xfer(1'b1, 8'h94, 8'h3C);
        for (int i = 0; i < 40 && pin_out[0] !== 1'b1; i++) @(posedge clk);
        check("buffered_set", 32'(pin_out[0]), 32'h1);
        // halted, so no wrap can void the clear between read and write
        xfer(1'b1, 8'h80, 8'h30);
        xfer(1'b0, 8'h80, 8'h00);
        xfer(1'b1, 8'h80, 8'h30);
        xfer(1'b1, 8'h8C, 8'h00);
        xfer(1'b1, 8'h80, 8'h00);
        repeat (30) @(posedge clk);
        xfer(1'b0, 8'h80, 8'h00); check("wrap_blocked", rd, 32'h0);
        xfer(1'b1, 8'h90, 8'h09);
        repeat (12) @(posedge clk);
        xfer(1'b0, 8'h80, 8'h00); check("wrap_unblocked", rd, 32'h80);
        xfer(1'b0, 8'hB0, 8'h00); check("unmapped_err", 32'(err), 32'h1);
        check("unmapped_data", rd, 32'h0);
        conclude();
    end
endmodule : ccpt_timer_bench
`default_nettype wire
